// File: tbu_checker.sv
// Port assertions for the transmit unpacker.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`include "tbu_defines.svh"
module tbu_checker (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Host bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// MAC stream
	input wire logic [31:0] mac_tx_data,
	input wire logic [3:0]  mac_tx_be,
	input wire logic        mac_tx_last,
	input wire logic        mac_tx_crc_disable,
	input wire logic        mac_tx_pad_disable,
	input wire logic        mac_tx_valid,
	input wire logic        mac_tx_ready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic st_rd_r;
	// Remembers whether the read in flight targets the status queue
	always_ff @(posedge aclk) begin
		if (!aresetn)
			st_rd_r <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			st_rd_r <= s_axi_araddr == `TBU_ADDR_STATUS;
	end
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) else $error("write response dropped early");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
	aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=>
		!s_axi_awready) else $error("second write address taken");
	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready |->
		##[1:300] s_axi_bvalid) else $error("write never answered");
	mac_hold_a: assert property (mac_tx_valid && !mac_tx_ready |=>
		$stable(mac_tx_data) && $stable(mac_tx_be) && $stable(mac_tx_last))
		else $error("stream word changed while waiting");
	crc_force_a: assert property (mac_tx_valid && mac_tx_pad_disable |->
		!mac_tx_crc_disable) else $error("check sequence off with no pad");
	lane_run_a: assert property (mac_tx_valid |-> mac_tx_be inside
		{4'h1, 4'h3, 4'h7, 4'hF, 4'h2, 4'h6, 4'hE, 4'h4, 4'hC, 4'h8})
		else $error("byte lanes not one run");
	es_or_a: assert property (s_axi_rvalid && st_rd_r && s_axi_rresp == 2'h0
		|-> s_axi_rdata[15] == |{s_axi_rdata[11:8], s_axi_rdata[2:1]})
		else $error("error summary wrong");
	rsvd_zero_a: assert property (s_axi_rvalid && st_rd_r |->
		s_axi_rdata[14:12] == 3'h0 && !s_axi_rdata[7] && !s_axi_rdata[1])
		else $error("reserved status bits set");
endmodule

bind tbu_core tbu_checker u_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .mac_tx_data, .mac_tx_be, .mac_tx_last,
	.mac_tx_crc_disable, .mac_tx_pad_disable, .mac_tx_valid, .mac_tx_ready);

// File: tbu_core.sv
// Transmit buffer unpacker with per-packet status queue and AXI4-Lite port.
// Assumes a MAC on the same clock taking words with byte enables and
// reporting each finished packet with a one-cycle done pulse.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "tbu_defines.svh"

module tbu_core
	import tbu_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Data words toward the MAC
	output logic [31:0]      mac_tx_data,
	output logic [3:0]       mac_tx_be,
	output logic             mac_tx_last,
	output logic             mac_tx_crc_disable,
	output logic             mac_tx_pad_disable,
	output logic             mac_tx_valid,
	input  wire logic        mac_tx_ready,
	output logic             mac_defer_check_enable,
	// Per-packet result from the MAC
	input  wire logic        mac_done,
	input  wire logic        mac_loss_carrier,
	input  wire logic        mac_no_carrier,
	input  wire logic        mac_late_collision,
	input  wire logic        mac_excess_collision,
	input  wire logic [3:0]  mac_collision_count,
	input  wire logic        mac_excess_deferral,
	input  wire logic        mac_deferred,
	// Status flags
	output logic             transmit_error_flag
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Words occupied after the commands, padding included
	function automatic logic [9:0] total_words(input logic [10:0] size,
		input logic [4:0] off, input logic [1:0] align);
		logic [11:0] tot;
		logic [11:0] am;
		logic [11:0] rnd;
		tot = {1'b0, size} + {7'h00, off};
		case (align)
			2'h1:    am = 12'h00F;
			2'h2:    am = 12'h01F;
			default: am = 12'h003;
		endcase
		rnd = (tot + am) & ~am;
		return rnd[11:2];
	endfunction

	// Words carrying payload bytes, partial edge words included
	function automatic logic [9:0] data_words(input logic [10:0] size,
		input logic [1:0] lane);
		logic [11:0] t;
		t = {1'b0, size} + {10'h000, lane} + 12'h003;
		return (size == 11'h000) ? 10'h000 : t[11:2];
	endfunction

	// Status word assembly
	function automatic tbu_word_t make_status(input logic [15:0] tag,
		input logic defchk);
		tbu_word_t s;
		s = 32'h0000_0000;
		s[31:16] = tag;
		s[`TBU_ST_LOSS] = mac_loss_carrier;
		s[`TBU_ST_NOCAR] = mac_no_carrier;
		s[`TBU_ST_LATE] = mac_late_collision;
		s[`TBU_ST_EXCOL] = mac_excess_collision;
		s[6:3] = mac_collision_count;
		s[`TBU_ST_DEFEXC] = mac_excess_deferral & defchk;
		s[`TBU_ST_DEFER] = mac_deferred;
		s[`TBU_ST_ES] = s[11] | s[10] | s[9] | s[8] | s[2] | s[1];
		return s;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0]      awaddr_r;
	logic            aw_held_r;
	logic [31:0]     wdata_r;
	logic [3:0]      wstrb_r;
	logic            w_held_r;
	logic [1:0]      bresp_r;
	logic            bvalid_r;
	logic [31:0]     rdata_r;
	logic [1:0]      rresp_r;
	logic            rvalid_r;
	logic [1:0]      cfg_r;
	logic            err_r;
	logic            ovr_seen_r;

	tbu_pstate_t     ps_r;
	logic [31:0]     cmda_r;
	logic [31:0]     pktb_r;
	logic [2:0]      skip_r;
	logic [9:0]      data_r;
	logic [9:0]      ndata_r;
	logic [9:0]      pad_r;
	logic [11:0]     sum_r;
	logic [15:0]     tag_r;

	logic [31:0]     out_data_r;
	logic [3:0]      out_be_r;
	logic            out_last_r;
	logic            out_nocrc_r;
	logic            out_nopad_r;
	logic            out_valid_r;

	tbu_word_t       stq_mem [`TBU_STQ_DEPTH];
	logic [`TBU_STQ_AW-1:0] stq_wp_r;
	logic [`TBU_STQ_AW-1:0] stq_rp_r;
	logic [`TBU_STQ_AW:0]   stq_cnt_r;

	logic            wr_go;
	logic            wr_data;
	logic            data_ok;
	logic            word_in;
	logic            rd_go;
	logic            rd_pop;
	logic            stq_full;
	logic            stq_push;
	logic            out_take;
	logic            tx_allow;
	logic            buf_end;
	logic            body_one;
	logic [11:0]     sum_nxt;
	logic            len_err;
	logic            b_err;
	logic            ovr_err;
	logic            err_clr;
	logic [3:0]      be_nxt;
	logic [1:0]      end_lane;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	assign s_axi_awready = ~aw_held_r;
	assign s_axi_wready  = ~w_held_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rvalid  = rvalid_r;

	assign wr_data = awaddr_r == `TBU_ADDR_DATA;
	// Data-port writes wait until the output word register can take one
	assign data_ok = ~out_valid_r | out_take;
	assign wr_go   = aw_held_r & w_held_r & ~bvalid_r & (~wr_data | data_ok);
	assign word_in = wr_go & wr_data;
	assign rd_go   = s_axi_arvalid & ~rvalid_r;
	assign rd_pop  = rd_go & (s_axi_araddr == `TBU_ADDR_STATUS) &
		(stq_cnt_r != 5'h00);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r  <= 8'h00;
		end else if (s_axi_awvalid && !aw_held_r) begin
			aw_held_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
		end else if (s_axi_wvalid && !w_held_r) begin
			w_held_r <= 1'b1;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= 2'h0;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			case (awaddr_r)
				`TBU_ADDR_DATA, `TBU_ADDR_CFG, `TBU_ADDR_INFO: bresp_r <= 2'h0;
				default: bresp_r <= 2'h2;
			endcase
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r <= `TBU_CFG_RESET;
		end else if (wr_go && awaddr_r == `TBU_ADDR_CFG && wstrb_r[0]) begin
			cfg_r <= wdata_r[1:0];
		end
	end

	assign err_clr = wr_go & (awaddr_r == `TBU_ADDR_INFO) & wstrb_r[1] &
		wdata_r[`TBU_INFO_ERR];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= 2'h0;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rresp_r  <= 2'h0;
			case (s_axi_araddr)
				`TBU_ADDR_STATUS:
					rdata_r <= rd_pop ? stq_mem[stq_rp_r] : 32'h0000_0000;
				`TBU_ADDR_CFG:
					rdata_r <= {30'h0000_0000, cfg_r};
				`TBU_ADDR_INFO:
					rdata_r <= {23'h00_0000, err_r, 3'h0,
						ovr_seen_r ? 5'h00 : stq_cnt_r};
				`TBU_ADDR_DATA:
					rdata_r <= 32'h0000_0000;
				default: begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= 2'h2;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Buffer parser

	assign body_one = ({7'h00, skip_r} + data_r + pad_r) == 10'h001;
	assign sum_nxt  = (cmda_r[`TBU_A_FIRST] ? 12'h000 : sum_r) +
		{1'b0, cmda_r[`TBU_A_SIZE_HI:0]};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ps_r    <= PS_CMDA;
			cmda_r  <= 32'h0000_0000;
			pktb_r  <= 32'h0000_0000;
			skip_r  <= 3'h0;
			data_r  <= 10'h000;
			ndata_r <= 10'h000;
			pad_r   <= 10'h000;
			sum_r   <= 12'h000;
		end else if (word_in) begin
			case (ps_r)
				PS_CMDA: begin
					cmda_r <= wdata_r;
					ps_r   <= PS_CMDB;
				end
				PS_CMDB: begin
					if (cmda_r[`TBU_A_FIRST]) begin
						pktb_r <= wdata_r;
					end
					sum_r   <= cmda_r[`TBU_A_FIRST] ?
						{1'b0, cmda_r[`TBU_A_SIZE_HI:0]} : sum_nxt;
					skip_r  <= cmda_r[`TBU_A_OFF_HI:18];
					data_r  <= data_words(cmda_r[10:0], cmda_r[17:16]);
					ndata_r <= data_words(cmda_r[10:0], cmda_r[17:16]);
					pad_r   <= total_words(cmda_r[10:0],
						cmda_r[`TBU_A_OFF_HI:`TBU_A_OFF_LO],
						cmda_r[`TBU_A_ALIGN_HI:`TBU_A_ALIGN_LO]) -
						{7'h00, cmda_r[`TBU_A_OFF_HI:18]} -
						data_words(cmda_r[10:0], cmda_r[17:16]);
					ps_r    <= PS_BODY;
				end
				PS_BODY: begin
					// Whole offset words first, then payload, then padding
					if (skip_r != 3'h0) begin
						skip_r <= skip_r - 3'h1;
					end else if (data_r != 10'h000) begin
						data_r <= data_r - 10'h001;
					end else if (pad_r != 10'h000) begin
						pad_r <= pad_r - 10'h001;
					end
					if (body_one) begin
						ps_r <= PS_CMDA;
					end
				end
				default: ps_r <= PS_CMDA;
			endcase
		end else if (ps_r == PS_BODY && skip_r == 3'h0 &&
			data_r == 10'h000 && pad_r == 10'h000) begin
			ps_r <= PS_CMDA;
		end
	end

	// Lane masks for the first and final payload words
	assign end_lane = cmda_r[17:16] + cmda_r[1:0] - 2'h1;
	always_comb begin
		be_nxt = 4'hF;
		if (data_r == ndata_r) begin
			be_nxt = be_nxt & (4'hF << cmda_r[17:16]);
		end
		if (data_r == 10'h001) begin
			be_nxt = be_nxt & (4'hF >> (2'h3 - end_lane));
		end
	end

	// Buffer end, packet length and second command word checks
	assign buf_end = word_in & (((ps_r == PS_BODY) & body_one) |
		((ps_r == PS_CMDB) & (total_words(cmda_r[10:0],
		cmda_r[20:16], cmda_r[25:24]) == 10'h000)));
	assign len_err = buf_end & cmda_r[`TBU_A_LAST] &
		(((ps_r == PS_CMDB) ? (cmda_r[`TBU_A_FIRST] ?
		{1'b0, cmda_r[10:0]} : sum_nxt) : sum_r) !=
		{1'b0, pktb_r[`TBU_B_LEN_HI:0]});
	assign b_err = word_in & (ps_r == PS_CMDB) & ~cmda_r[`TBU_A_FIRST] &
		(wdata_r != pktb_r);

	////////////////////////////////////////////////////////////////////////
	// Output word register toward the MAC

	assign tx_allow     = cfg_r[`TBU_CFG_DISCARD] | ~stq_full;
	assign mac_tx_valid = out_valid_r & tx_allow;
	assign out_take     = mac_tx_valid & mac_tx_ready;

	assign mac_tx_data            = out_data_r;
	assign mac_tx_be              = out_be_r;
	assign mac_tx_last            = out_last_r;
	assign mac_tx_crc_disable     = out_nocrc_r;
	assign mac_tx_pad_disable     = out_nopad_r;
	assign mac_defer_check_enable = cfg_r[`TBU_CFG_DEFER_CHK];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_valid_r <= 1'b0;
			out_data_r  <= 32'h0000_0000;
			out_be_r    <= 4'h0;
			out_last_r  <= 1'b0;
			out_nocrc_r <= 1'b0;
			out_nopad_r <= 1'b0;
		end else if (word_in && ps_r == PS_BODY && skip_r == 3'h0 &&
			data_r != 10'h000) begin
			// Only payload words leave; commands and whole pads never do
			out_valid_r <= 1'b1;
			out_data_r  <= wdata_r;
			out_be_r    <= be_nxt;
			out_last_r  <= cmda_r[`TBU_A_LAST] & (data_r == 10'h001);
			out_nopad_r <= pktb_r[`TBU_B_NOPAD];
			out_nocrc_r <= pktb_r[`TBU_B_NOCRC] & ~pktb_r[`TBU_B_NOPAD];
		end else if (out_take) begin
			out_valid_r <= 1'b0;
		end
	end

	// Tag of the packet whose final word went to the MAC
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tag_r <= 16'h0000;
		end else if (out_take && out_last_r) begin
			tag_r <= pktb_r[`TBU_B_TAG_HI:`TBU_B_TAG_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status queue

	assign stq_full = stq_cnt_r == 5'h10;
	assign stq_push = mac_done & ~stq_full;
	assign ovr_err  = mac_done & stq_full & ~cfg_r[`TBU_CFG_DISCARD];

	always_ff @(posedge aclk) begin
		if (stq_push) begin
			stq_mem[stq_wp_r] <= make_status(tag_r,
				cfg_r[`TBU_CFG_DEFER_CHK]);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stq_wp_r  <= 4'h0;
			stq_rp_r  <= 4'h0;
			stq_cnt_r <= 5'h00;
		end else begin
			if (stq_push) begin
				stq_wp_r <= stq_wp_r + 4'h1;
			end
			if (rd_pop) begin
				stq_rp_r <= stq_rp_r + 4'h1;
			end
			case ({stq_push, rd_pop})
				2'b10:   stq_cnt_r <= stq_cnt_r + 5'h01;
				2'b01:   stq_cnt_r <= stq_cnt_r - 5'h01;
				default: stq_cnt_r <= stq_cnt_r;
			endcase
		end
	end

	// Discard-mode overrun shows a used count of zero until the host pops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovr_seen_r <= 1'b0;
		end else if (mac_done && stq_full && cfg_r[`TBU_CFG_DISCARD]) begin
			ovr_seen_r <= 1'b1;
		end else if (rd_pop) begin
			ovr_seen_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit error flag, set wins over clear

	assign transmit_error_flag = err_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_r <= 1'b0;
		end else if (len_err || b_err || ovr_err) begin
			err_r <= 1'b1;
		end else if (err_clr) begin
			err_r <= 1'b0;
		end
	end

endmodule

// File: tbu_core_tb_top.sv
// Self-checking bench for the transmit unpacker.
// Assumes the MAC model beside the design and the bound checker.
`timescale 1ns/10ps
`include "tbu_defines.svh"
module tbu_core_tb_top;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, mac_tx_last;
	logic        mac_tx_crc_disable, mac_tx_pad_disable, mac_tx_valid;
	logic        mac_tx_ready, mac_defer_check_enable, mac_done, slow, ed;
	logic        mac_loss_carrier, mac_no_carrier, mac_late_collision;
	logic        mac_excess_collision, mac_excess_deferral, mac_deferred;
	logic        transmit_error_flag;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [2:0]  c;
	logic [3:0]  s_axi_wstrb, mac_tx_be, mac_collision_count;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [9:0]  res;
	logic [31:0] s_axi_wdata, s_axi_rdata, mac_tx_data, rd;
	logic [63:0] exp_q[$];
	int          err_count, num_checks;

	tbu_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mac_tx_data, .mac_tx_be,
		.mac_tx_last, .mac_tx_crc_disable, .mac_tx_pad_disable, .mac_tx_valid,
		.mac_tx_ready, .mac_defer_check_enable, .mac_done, .mac_loss_carrier,
		.mac_no_carrier, .mac_late_collision, .mac_excess_collision,
		.mac_collision_count, .mac_excess_deferral, .mac_deferred,
		.transmit_error_flag);
	tbu_mac_model mdl (.aclk, .aresetn, .slow, .res, .mac_tx_data,
		.mac_tx_be, .mac_tx_last, .mac_tx_crc_disable, .mac_tx_pad_disable,
		.mac_tx_valid, .mac_tx_ready, .mac_done, .mac_loss_carrier,
		.mac_no_carrier, .mac_late_collision, .mac_excess_collision,
		.mac_collision_count, .mac_excess_deferral, .mac_deferred);

	////////////////////////////////////////
	task automatic final_report(input bit to);
		if (to)
			err_count++;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] msk(input logic [3:0] b);
		return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
	endfunction
	// One bus access; w picks write or read, result in rd and rsp
	task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		do begin
			@(posedge aclk);
			n++;
			if (n > 3000)
				final_report(1'b1);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (!(w ? s_axi_bvalid === 1'b1 : s_axi_rvalid === 1'b1));
		rsp = w ? s_axi_bresp : s_axi_rresp;
		rd = s_axi_rdata;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask
	// Writes one buffer and queues the stream words it must yield
	task automatic buf_w(input logic [15:0] tg, input logic [1:0] fl,
		input logic [4:0] off, input logic [10:0] sz, input logic [10:0] ln,
		input logic [1:0] al, input logic [1:0] bf);
		int ab, tot, sk, n, k;
		logic [3:0] be;
		logic [31:0] d;
		ab = al == 2'h2 ? 32 : (al == 2'h1 ? 16 : 4);
		tot = (off + sz + ab - 1) / ab * ab / 4;
		sk = off[4:2];
		n = sz == 0 ? 0 : (off[1:0] + sz + 3) / 4;
		xfer(1'b1, `TBU_ADDR_DATA, {6'h00, al, 3'h0, off, 2'h0, bf, 1'b0, sz});
		xfer(1'b1, `TBU_ADDR_DATA, {tg, 2'h0, fl, 1'b0, ln});
		for (int j = 0; j < tot; j++) begin
			d = {8'(j), tg[7:0], 16'h5A3C};
			k = j - sk;
			if (k >= 0 && k < n) begin
				be = 4'hF;
				if (k == 0)
					be = be & (4'hF << off[1:0]);
				if (k == n - 1)
					be = be & (4'hF >> (3 - (off[1:0] + sz - 1) % 4));
				exp_q.push_back({fl[1] & ~fl[0], fl[0], bf[0] && k == n - 1,
					be, d & msk(be)});
			end
			xfer(1'b1, `TBU_ADDR_DATA, d);
		end
	endtask
	task automatic drain;
		logic [38:0] g;
		logic [63:0] e;
		for (int n = 0; n < 300 && mdl.got_q.size() < exp_q.size(); n++)
			@(posedge aclk);
		if (mdl.got_q.size() < exp_q.size())
			final_report(1'b1);
		repeat (6) @(posedge aclk);
		chk(mdl.got_q.size(), exp_q.size());
		while (mdl.got_q.size() > 0 && exp_q.size() > 0) begin
			g = mdl.got_q.pop_front();
			e = exp_q.pop_front();
			chk({g[38:32], g[31:0] & msk(g[35:32])}, e);
		end
	endtask

	////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, slow} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		res = 10'h000;
		err_count = 0;
		num_checks = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({transmit_error_flag, mac_tx_valid, s_axi_bvalid, s_axi_awready}, 4'h1);
		xfer(1'b0, `TBU_ADDR_CFG, 32'h0);
		chk(rd, 32'h0);
		xfer(1'b0, 8'h40, 32'h0);
		chk({rsp, rd}, {2'h2, 32'h0});
		xfer(1'b1, 8'h40, 32'hFFFFFFFF);
		chk(rsp, 2'h2);
		xfer(1'b1, `TBU_ADDR_STATUS, 32'h1);
		chk(rsp, 2'h2);
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			xfer(1'b1, `TBU_ADDR_CFG, {30'h0, c[0], 1'b0});
			res <= (10'h001 << i) | (c[0] ? 10'h300 : 10'h000) | (c[2] ? 10'h002 : 10'h000);
			slow <= c[0];
			buf_w({8'hA5, 5'h00, c}, c[1:0], 5'(i * 7), 11'(1 + i * 9),
				11'(1 + i * 9), 2'(i % 3), 2'h3);
			drain;
			chk(mac_defer_check_enable, c[0]);
			ed = res[1] & c[0];
			xfer(1'b0, `TBU_ADDR_STATUS, 32'h0);
			chk(rd, {8'hA5, 5'h00, c, (|res[9:6] | ed), 3'h0, res[9:6], 1'b0, res[5:2], ed, 1'b0, res[0]});
			xfer(1'b0, `TBU_ADDR_INFO, 32'h0);
			chk(rd & 32'h11F, 32'h0);
		end
		res <= 10'h000;
		buf_w(16'h5C01, 2'h1, 5'h01, 11'h003, 11'h00A, 2'h0, 2'h2);
		buf_w(16'h5C01, 2'h1, 5'h00, 11'h004, 11'h00A, 2'h1, 2'h0);
		buf_w(16'h5C01, 2'h1, 5'h02, 11'h002, 11'h00A, 2'h2, 2'h1);
		drain;
		chk(transmit_error_flag, 1'b1);
		xfer(1'b0, `TBU_ADDR_STATUS, 32'h0);
		chk(rd, 32'h5C010000);
		xfer(1'b1, `TBU_ADDR_INFO, 32'h100);
		xfer(1'b0, `TBU_ADDR_INFO, 32'h0);
		chk(rd, 32'h0);
		xfer(1'b1, `TBU_ADDR_CFG, 32'h1);
		for (int i = 0; i < 17; i++) begin
			buf_w({8'h3C, 3'h0, 5'(i)}, 2'h0, 5'h00, 11'h004, 11'h004, 2'h0, 2'h3);
			drain;
		end
		xfer(1'b0, `TBU_ADDR_INFO, 32'h0);
		chk(rd & 32'h11F, 32'h0);
		chk(transmit_error_flag, 1'b0);
		xfer(1'b1, `TBU_ADDR_CFG, 32'h0);
		buf_w(16'h3C20, 2'h0, 5'h00, 11'h004, 11'h004, 2'h0, 2'h3);
		repeat (4) @(posedge aclk);
		chk(mac_tx_valid, 1'b0);
		xfer(1'b0, `TBU_ADDR_STATUS, 32'h0);
		chk(rd[31:16], 16'h3C00);
		drain;
		xfer(1'b0, `TBU_ADDR_INFO, 32'h0);
		chk(rd & 32'h11F, 32'h10);
		final_report(1'b0);
	end
endmodule

// File: tbu_defines.svh
// Offsets, field positions, reset values and limits of the transmit unpacker.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TBU_DEFINES_SVH
`define TBU_DEFINES_SVH

// Register byte addresses
`define TBU_ADDR_DATA      8'h00
`define TBU_ADDR_STATUS    8'h04
`define TBU_ADDR_CFG       8'h08
`define TBU_ADDR_INFO      8'h0C

// Configuration and info bits
`define TBU_CFG_DISCARD    0
`define TBU_CFG_DEFER_CHK  1
`define TBU_CFG_RESET      2'h0
`define TBU_INFO_ERR       8

// First command word fields
`define TBU_A_SIZE_HI      10
`define TBU_A_LAST         12
`define TBU_A_FIRST        13
`define TBU_A_OFF_HI       20
`define TBU_A_OFF_LO       16
`define TBU_A_ALIGN_HI     25
`define TBU_A_ALIGN_LO     24

// Second command word fields
`define TBU_B_LEN_HI       10
`define TBU_B_NOPAD        12
`define TBU_B_NOCRC        13
`define TBU_B_TAG_HI       31
`define TBU_B_TAG_LO       16

// Status word bit positions
`define TBU_ST_ES          15
`define TBU_ST_LOSS        11
`define TBU_ST_NOCAR       10
`define TBU_ST_LATE        9
`define TBU_ST_EXCOL       8
`define TBU_ST_DEFEXC      2
`define TBU_ST_DEFER       0

// Status queue depth
`define TBU_STQ_DEPTH      16
`define TBU_STQ_AW         4

`endif

// File: tbu_mac_model.sv
// Behavioural MAC taking stream words and reporting each finished packet.
// Assumes the bench reads got_q and sets res before each packet.
`timescale 1ns/10ps
module tbu_mac_model (
	// Clock, reset and bench control
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        slow,
	input wire logic [9:0]  res,
	// Stream in
	input wire logic [31:0] mac_tx_data,
	input wire logic [3:0]  mac_tx_be,
	input wire logic        mac_tx_last,
	input wire logic        mac_tx_crc_disable,
	input wire logic        mac_tx_pad_disable,
	input wire logic        mac_tx_valid,
	output logic            mac_tx_ready,
	// Packet result
	output logic            mac_done,
	output logic            mac_loss_carrier,
	output logic            mac_no_carrier,
	output logic            mac_late_collision,
	output logic            mac_excess_collision,
	output logic [3:0]      mac_collision_count,
	output logic            mac_excess_deferral,
	output logic            mac_deferred
);
	logic [38:0] got_q[$];
	logic [1:0]  due_r;
	logic [9:0]  out_v;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mac_tx_ready <= 1'b0;
			mac_done <= 1'b0;
			due_r <= 2'h0;
		end else begin
			mac_tx_ready <= slow ? !mac_tx_ready : 1'b1;
			mac_done <= due_r == 2'h1;
			if (due_r != 2'h0)
				due_r <= due_r - 2'h1;
			if (mac_tx_valid && mac_tx_ready) begin
				got_q.push_back({mac_tx_crc_disable, mac_tx_pad_disable,
					mac_tx_last, mac_tx_be, mac_tx_data});
				if (mac_tx_last)
					due_r <= 2'h3;
			end
		end
	end
	// Result lines carry garbage outside the done cycle
	assign out_v = mac_done ? res : ~res;
	assign {mac_loss_carrier, mac_no_carrier, mac_late_collision,
		mac_excess_collision, mac_collision_count, mac_excess_deferral,
		mac_deferred} = out_v;
endmodule

// File: tbu_pkg.sv
// Types shared by the transmit unpacker.
// Assumes tbu_defines.svh is on the include path.
`include "tbu_defines.svh"

package tbu_pkg;

	typedef enum logic [1:0] {
		PS_CMDA = 2'b00,
		PS_CMDB = 2'b01,
		PS_BODY = 2'b10
	} tbu_pstate_t;

	typedef logic [31:0] tbu_word_t;

endpackage
